//--- rtl/prss_defs.vh
/*
 * constants for the power, reset and sleep sequencer: timing counts,
 * apb register offsets, field positions and reset values.
 * assumes clk_sys at 10 MHz; included by bare name.
 */
`ifndef PRSS_DEFS_VH
`define PRSS_DEFS_VH

// ****************************************
// timing
// ****************************************
`define PRSS_CLK_HZ 10000000
`define PRSS_POR_DELAY_US 2500
`define PRSS_POR_DELAY_CYC ((`PRSS_POR_DELAY_US * (`PRSS_CLK_HZ / 1000000)))
`define PRSS_IO_MON_US 9000
`define PRSS_IO_MON_CYC ((`PRSS_IO_MON_US * (`PRSS_CLK_HZ / 1000000)))
`define PRSS_INSTANT_US 10
`define PRSS_INSTANT_CYC ((`PRSS_INSTANT_US * (`PRSS_CLK_HZ / 1000000)))
`define PRSS_WAKE_MAX_US 1000
`define PRSS_WAKE_MAX_CYC ((`PRSS_WAKE_MAX_US * (`PRSS_CLK_HZ / 1000000)))
`define PRSS_STEP_CYC 4
`define PRSS_CNT_W 17

// ****************************************
// registers
// ****************************************
`define PRSS_REG_CTRL 12'h000
`define PRSS_REG_STAT 12'h004
`define PRSS_REG_OBUF 12'h008
`define PRSS_REG_IBUF 12'h00c
`define PRSS_REG_CNT 12'h010
`define PRSS_REG_ID 12'h014

`define PRSS_CTRL_SLEEP_SW 0
`define PRSS_CTRL_SYNC_GATE 1
`define PRSS_CTRL_INSTANT 2
`define PRSS_CTRL_DUAL 3
`define PRSS_CTRL_RST 32'h0000_0000

`define PRSS_NBANK 8
`define PRSS_NOBUF 16
`define PRSS_NGCLK 4
`define PRSS_IBUF_RST 8'hff
`define PRSS_OBUF_RST 16'hffff

// ****************************************
// sleep states
// ****************************************
`define PRSS_ST_AWAKE 2'b00
`define PRSS_ST_ENTER 2'b01
`define PRSS_ST_SLEEP 2'b10
`define PRSS_ST_EXIT 2'b11

`endif

//--- rtl/prss_sync2.v
/*
 * two-stage level synchroniser.
 * assumes d is a level from outside clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none

module prss_sync2 (
  input wire clk_sys,
  input wire rst_b,
  input wire d,
  output wire q
);

  reg meta_r;
  reg sync_r;

  // first stage feeds only the second
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule // prss_sync2

`default_nettype wire

//--- rtl/prss_rail_det.v
/*
 * one supply detector: filters a rail-good comparator level and
 * reports release. assumes rail_ok is synchronous to clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none

module prss_rail_det (
  input wire clk_sys,
  input wire rst_b,
  input wire enable,
  input wire rail_ok,
  output reg released_r
);

  reg seen_r;

  // two agreeing samples before release; drop is immediate
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seen_r <= 1'b0;
      released_r <= 1'b0;
    end else begin
      seen_r <= rail_ok;
      released_r <= !enable || (rail_ok && seen_r);
    end
  end

endmodule // prss_rail_det

`default_nettype wire

//--- rtl/prss_top.v
/*
 * power-on reset sequencer and sleep controller with an apb slave.
 * assumes rail comparators, sleep request and apb synchronous to
 * clk_sys (the internal oscillator); sleep request held low until
 * configuration is done.
 */
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none

`include "prss_defs.vh"

// Summary of operation
// R01: each configuration rail has its own detector; release needs all released
// R02: main reset releases after last rail trips plus 2.5 ms delay
// R03: configuration start only after main reset has been released
// R04: single part watches one rail, analog, bank supplies; dual ignores others
// R05: in user mode analog or core drop reasserts main reset
// R06: bank supply drop never resets; its watch ends 9 ms after last trip; here resets before user mode, watch ends 9 ms after reset release
// R07: instant-on uses a short delay instead of the full reset delay
// R08: sleep powers buffers down and gates global clock networks
// R09: one port carries the sleep enter and exit request
// R10: controller runs on internal oscillator, enable held at 1
// R11: normal operation is restored within 1 ms of wake
// R12: input power per bank for listed standards; output enable per buffer
// R13: banks 1A and 1B share one input power control
// R14: buffer controls held at 1 during power-up and configuration; here output enables are held at 0 until user mode
// R15: controller defaults buffer controls to 1 after configuration
// R16: a control at 0 powers down or tri-states its buffers
// R17: buffers and core keep their state through sleep
// R18: clock enable low gates the network; its logic stays off
// R19: network gating sync or async; ungating always async
// R20: outputs tri-stated until configured and conditions are valid
// R21: sleep goes through entering to sleep; wake through exiting to awake
// R22: sleep request held low during power-up and configuration
// R23: in sleep both buffer controls are pulled low
// R24: sleep request passes a two-stage synchroniser first
module prss_top #(
  parameter POR_DELAY_CYC = `PRSS_POR_DELAY_CYC,
  parameter IO_MON_CYC = `PRSS_IO_MON_CYC,
  parameter [31:0] ID_VALUE = 32'h0000_5a01 // arbitrary value
) (
  input wire clk_sys,
  input wire rst_b,
  input wire single_supply_rail_ok,
  input wire core_supply_ok,
  input wire analog_supply_rail_ok,
  input wire io_bank_1b_supply_ok,
  input wire io_bank_8_supply_ok,
  input wire config_done,
  input wire sleep_req,
  input wire [`PRSS_NGCLK-1:0] global_clock_network_async_up,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  output reg power_on_reset_b_r,
  output wire config_start,
  output wire internal_clock_enable,
  output wire [`PRSS_NGCLK-1:0] clock_network_enable,
  output wire [`PRSS_NBANK-1:0] input_buffer_power_n,
  output wire [`PRSS_NOBUF-1:0] output_buffer_enable,
  output wire sleep_status,
  output reg io_drop_seen_r
);

  // ****************************************
  // registers
  // ****************************************
  reg [31:0] ctrl_r;
  reg [`PRSS_NBANK-1:0] ibuf_r;
  reg [`PRSS_NOBUF-1:0] obuf_r;
  reg [`PRSS_CNT_W-1:0] por_cnt_r;
  reg [`PRSS_CNT_W-1:0] io_cnt_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] step_r;
  reg [`PRSS_NGCLK-1:0] gate_r;
  reg buf_sleep_r;
  reg user_mode_r;
  reg io_watch_r;
  reg [7:0] sleep_cnt_r;

  wire dual = ctrl_r[`PRSS_CTRL_DUAL];
  wire instant = ctrl_r[`PRSS_CTRL_INSTANT];
  wire sleep_sync;
  wire [3:0] det_rel;
  wire [3:0] det_ok;
  wire all_rel;
  wire brown_out;
  wire [`PRSS_CNT_W-1:0] por_target;

  // ****************************************
  // rail detectors
  // ****************************************
  // dual part: core instead of single rail; pll, converter and internal
  // supplies are simply not wired in
  assign det_ok[0] = dual ? core_supply_ok : single_supply_rail_ok; // R04
  assign det_ok[1] = analog_supply_rail_ok; // R04
  assign det_ok[2] = io_bank_1b_supply_ok; // R04
  assign det_ok[3] = io_bank_8_supply_ok; // R04

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_det
      prss_rail_det u_det (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .enable(1'b1),
        .rail_ok(det_ok[gi]),
        .released_r(det_rel[gi])
      ); // R01
    end
  endgenerate

  assign all_rel = &det_rel; // R01
  // bank supplies excluded: their drop must not reset the part
  assign brown_out = !det_rel[0] || !det_rel[1]; // R05 R06

  // ****************************************
  // main power-on reset
  // ****************************************
  // all three delays cut to the counter width on purpose; defaults fit in it
  localparam integer INSTANT_CYC = `PRSS_INSTANT_CYC;
  localparam [`PRSS_CNT_W-1:0] POR_CYC_W = POR_DELAY_CYC[`PRSS_CNT_W-1:0];
  localparam [`PRSS_CNT_W-1:0] INSTANT_CYC_W = INSTANT_CYC[`PRSS_CNT_W-1:0];
  localparam [`PRSS_CNT_W-1:0] IO_MON_CYC_W = IO_MON_CYC[`PRSS_CNT_W-1:0];

  // instant-on trades the full settling delay for a short fixed one
  assign por_target = instant ? INSTANT_CYC_W : POR_CYC_W; // R07

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt_r <= {`PRSS_CNT_W{1'b0}};
      power_on_reset_b_r <= 1'b0;
    end else if (!all_rel && (!user_mode_r || brown_out)) begin
      por_cnt_r <= {`PRSS_CNT_W{1'b0}}; // R02 R05
      power_on_reset_b_r <= 1'b0;
    end else if (!power_on_reset_b_r) begin
      if (por_cnt_r >= por_target - 1'b1) begin
        power_on_reset_b_r <= 1'b1; // R02 R07
      end else begin
        por_cnt_r <= por_cnt_r + 1'b1;
      end
    end
  end

  // ****************************************
  // configuration and user mode
  // ****************************************

  // configuration may start only with main reset released
  assign config_start = power_on_reset_b_r && !user_mode_r; // R03

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      user_mode_r <= 1'b0;
    end else if (!power_on_reset_b_r) begin
      user_mode_r <= 1'b0;
    end else if (config_done) begin
      user_mode_r <= 1'b1;
    end
  end

  // ****************************************
  // bank supply watch window
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      io_cnt_r <= {`PRSS_CNT_W{1'b0}};
      io_watch_r <= 1'b0;
      io_drop_seen_r <= 1'b0;
    end else if (!power_on_reset_b_r) begin
      io_cnt_r <= {`PRSS_CNT_W{1'b0}};
      io_watch_r <= all_rel;
      io_drop_seen_r <= 1'b0;
    end else if (io_watch_r) begin
      if (!det_rel[2] || !det_rel[3]) begin
        io_drop_seen_r <= 1'b1; // R06
      end
      if (io_cnt_r >= IO_MON_CYC_W - 1'b1) begin
        io_watch_r <= 1'b0; // R06
      end else begin
        io_cnt_r <= io_cnt_r + 1'b1;
      end
    end
  end

  // ****************************************
  // sleep controller
  // ****************************************
  prss_sync2 u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d(sleep_req || ctrl_r[`PRSS_CTRL_SLEEP_SW]),
    .q(sleep_sync)
  ); // R09 R24

  // request ignored until user mode
  wire sleep_want = sleep_sync && user_mode_r; // R22

  // ****************************************
  // sleep state machine
  // ****************************************

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `PRSS_ST_AWAKE: begin
        if (sleep_want) state_nxt = `PRSS_ST_ENTER; // R21
      end
      `PRSS_ST_ENTER: begin
        if (step_r == `PRSS_STEP_CYC - 1) state_nxt = `PRSS_ST_SLEEP; // R21
      end
      `PRSS_ST_SLEEP: begin
        if (!sleep_want) state_nxt = `PRSS_ST_EXIT; // R21
      end
      `PRSS_ST_EXIT: begin
        if (step_r == `PRSS_STEP_CYC - 1) state_nxt = `PRSS_ST_AWAKE; // R11 R21
      end
      default: state_nxt = `PRSS_ST_AWAKE;
    endcase
  end

  // ****************************************
  // power-down sequencing
  // ****************************************

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= `PRSS_ST_AWAKE;
      step_r <= 3'd0;
      buf_sleep_r <= 1'b0;
      gate_r <= {`PRSS_NGCLK{1'b0}};
      sleep_cnt_r <= 8'h00;
    end else if (!user_mode_r) begin
      state_r <= `PRSS_ST_AWAKE;
      step_r <= 3'd0;
      buf_sleep_r <= 1'b0; // R14
      gate_r <= {`PRSS_NGCLK{1'b0}};
    end else begin
      state_r <= state_nxt;
      step_r <= (state_nxt != state_r) ? 3'd0 : step_r + 3'd1;
      if (state_r == `PRSS_ST_ENTER) begin
        // buffers first, then clocks
        buf_sleep_r <= 1'b1; // R08 R23
        if (step_r == 3'd1) begin
          if (ctrl_r[`PRSS_CTRL_SYNC_GATE]) gate_r <= {`PRSS_NGCLK{1'b1}}; // R19
        end
        if (state_nxt == `PRSS_ST_SLEEP) begin
          gate_r <= {`PRSS_NGCLK{1'b1}}; // R08 R18
          sleep_cnt_r <= sleep_cnt_r + 8'h01;
        end
      end else if (state_r == `PRSS_ST_EXIT) begin
        gate_r <= {`PRSS_NGCLK{1'b0}}; // R11
        if (state_nxt == `PRSS_ST_AWAKE) buf_sleep_r <= 1'b0; // R11
      end
    end
  end

  // ****************************************
  // clock network enables
  // ****************************************

  // ungating bypasses the clocked path for an immediate power-up
  assign clock_network_enable = ~gate_r | global_clock_network_async_up; // R18 R19
  assign sleep_status = (state_r != `PRSS_ST_AWAKE); // R21
  assign internal_clock_enable = 1'b1; // R10

  // ****************************************
  // buffer controls
  // ****************************************
  // held low by power: outputs never drive before user mode
  wire buf_live = user_mode_r && power_on_reset_b_r; // R20
  generate
    for (gi = 0; gi < `PRSS_NBANK; gi = gi + 1) begin : g_ib
      // index 0 serves banks 1A and 1B together
      assign input_buffer_power_n[gi] = !buf_live ? 1'b1 :
        (ibuf_r[gi] & ~buf_sleep_r); // R12 R13 R14 R15 R16 R17
    end
    for (gi = 0; gi < `PRSS_NOBUF; gi = gi + 1) begin : g_ob
      assign output_buffer_enable[gi] = buf_live & obuf_r[gi] & ~buf_sleep_r; // R12 R16 R20
    end
  endgenerate

  // ****************************************
  // apb slave
  // ****************************************
  wire wr_en = psel && penable && pwrite;
  wire rd_hit = (paddr == `PRSS_REG_CTRL) || (paddr == `PRSS_REG_STAT) ||
    (paddr == `PRSS_REG_OBUF) || (paddr == `PRSS_REG_IBUF) ||
    (paddr == `PRSS_REG_CNT) || (paddr == `PRSS_REG_ID);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  // ****************************************
  // apb write
  // ****************************************

  // writes to status, count and id fall to the default and change nothing
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `PRSS_CTRL_RST;
      ibuf_r <= `PRSS_IBUF_RST;
      obuf_r <= `PRSS_OBUF_RST;
    end else if (wr_en) begin
      case (paddr)
        `PRSS_REG_CTRL: ctrl_r <= {28'h0000000, pwdata[3:0]};
        `PRSS_REG_OBUF: obuf_r <= pwdata[`PRSS_NOBUF-1:0];
        `PRSS_REG_IBUF: ibuf_r <= pwdata[`PRSS_NBANK-1:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // ****************************************
  // apb read
  // ****************************************

  // status word: gating, detector releases, bank drop, user mode, state
  wire [31:0] stat_word = {20'h00000, gate_r, det_rel, io_drop_seen_r,
    user_mode_r, state_r};

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PRSS_REG_CTRL: prdata <= ctrl_r;
        `PRSS_REG_STAT: prdata <= stat_word;
        `PRSS_REG_OBUF: prdata <= {16'h0000, obuf_r};
        `PRSS_REG_IBUF: prdata <= {24'h000000, ibuf_r};
        `PRSS_REG_CNT: prdata <= {24'h000000, sleep_cnt_r};
        `PRSS_REG_ID: prdata <= ID_VALUE;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // prss_top

`default_nettype wire

//--- verif/prss_chk.sv
/*
 * port checker for prss_top.
 * assumes one clock, async active-low reset; bound into every prss_top.
 */
`timescale 1ns/100ps
`default_nettype none
module prss_chk #(
  parameter POR_DELAY_CYC = 20,
  parameter IO_MON_CYC = 30
) (
  input wire clk_sys,
  input wire rst_b,
  input wire single_supply_rail_ok,
  input wire core_supply_ok,
  input wire analog_supply_rail_ok,
  input wire io_bank_8_supply_ok,
  input wire config_done,
  input wire sleep_req,
  input wire [3:0] global_clock_network_async_up,
  input wire power_on_reset_b_r,
  input wire config_start,
  input wire [3:0] clock_network_enable,
  input wire [7:0] input_buffer_power_n,
  input wire [15:0] output_buffer_enable,
  input wire sleep_status
);
  // ****
  // properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_user;
    power_on_reset_b_r && config_done && analog_supply_rail_ok && core_supply_ok;
  endsequence
  sequence s_down;
    (input_buffer_power_n == 8'h00 && output_buffer_enable == 16'h0000)
      ##[1:6] clock_network_enable == 4'h0;
  endsequence
  a_cfg_after_por: assert property (config_start |-> power_on_reset_b_r &&
    !$past(power_on_reset_b_r && config_done))
    else $error("config start while in reset");
  a_por_delay: assert property ($rose(power_on_reset_b_r) |->
    $past(analog_supply_rail_ok, POR_DELAY_CYC) && io_bank_8_supply_ok)
    else $error("reset released too early");
  a_reset_tristate: assert property (!power_on_reset_b_r |->
    output_buffer_enable == 16'h0000 && input_buffer_power_n == 8'hff)
    else $error("buffers active in reset");
  a_brownout_rst: assert property ((s_user ##1 $fell(analog_supply_rail_ok))
    |-> ##[1:4] !power_on_reset_b_r) else $error("no brownout reset");
  a_io_drop_ok: assert property ((s_user ##1 (s_user and !io_bank_8_supply_ok))
    |=> power_on_reset_b_r [*2]) else $error("bank drop reset device");
  a_enter_sync: assert property ((s_user and ($rose(sleep_req) && !sleep_status))
    |-> ##1 !sleep_status ##[1:3] sleep_status) else $error("sleep entry timing");
  a_sleep_down: assert property (($rose(sleep_status) && global_clock_network_async_up == 4'h0)
    |-> ##[1:2] s_down) else $error("sleep did not power down");
  a_wake_time: assert property (($fell(sleep_req) && sleep_status)
    |-> ##[1:1000] !sleep_status) else $error("wake too slow");
  a_clk_up: assert property (($fell(sleep_req) && sleep_status)
    |-> ##[1:8] clock_network_enable == 4'hf) else $error("clocks not restored");
  a_async_up: assert property ((global_clock_network_async_up & ~clock_network_enable) == 4'h0)
    else $error("async power-up ignored");
endmodule // prss_chk
bind prss_top prss_chk #(.POR_DELAY_CYC(POR_DELAY_CYC), .IO_MON_CYC(IO_MON_CYC)) prss_chk_i (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .single_supply_rail_ok(single_supply_rail_ok),
  .core_supply_ok(core_supply_ok),
  .analog_supply_rail_ok(analog_supply_rail_ok),
  .io_bank_8_supply_ok(io_bank_8_supply_ok),
  .config_done(config_done),
  .sleep_req(sleep_req),
  .global_clock_network_async_up(global_clock_network_async_up),
  .power_on_reset_b_r(power_on_reset_b_r),
  .config_start(config_start),
  .clock_network_enable(clock_network_enable),
  .input_buffer_power_n(input_buffer_power_n),
  .output_buffer_enable(output_buffer_enable),
  .sleep_status(sleep_status)
);
`default_nettype wire

//--- verif/prss_sleep_src.sv
/*
 * sleep request source at the far side.
 * assumes cfg_done marks the end of configuration.
 */
`timescale 1ns/100ps
`default_nettype none
module prss_sleep_src (
  input wire clk_sys,
  input wire cfg_done,
  input wire want,
  output logic sleep_req
);
  // held low until configured, whatever the user wants
  always @(posedge clk_sys) begin
    sleep_req <= want && cfg_done;
  end
endmodule // prss_sleep_src
`default_nettype wire

//--- verif/testbench.sv
/*
 * self-checking bench for prss_top.
 * assumes 10 MHz clk_sys; apb master and rail levels driven here.
 */
`timescale 1ns/100ps
`default_nettype none
`include "prss_defs.vh"
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic rail = 1'b0, ana = 1'b0, io8 = 1'b0, cfg = 1'b0, want = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [3:0] gup = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire sreq, pready, pslverr, porb, cst, osc, sst, iod;
  wire [31:0] prdata;
  wire [3:0] cne;
  wire [7:0] ibn;
  wire [15:0] obe;
  int fails = 0, n_checks = 0;
  always #50 clk_sys = ~clk_sys;
  prss_top #(.POR_DELAY_CYC(20), .IO_MON_CYC(30)) prss_top_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .single_supply_rail_ok(rail), .core_supply_ok(rail),
    .analog_supply_rail_ok(ana), .io_bank_1b_supply_ok(rail), .io_bank_8_supply_ok(io8),
    .config_done(cfg), .sleep_req(sreq), .global_clock_network_async_up(gup), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .power_on_reset_b_r(porb), .config_start(cst),
    .internal_clock_enable(osc), .clock_network_enable(cne), .input_buffer_power_n(ibn),
    .output_buffer_enable(obe), .sleep_status(sst), .io_drop_seen_r(iod));
  prss_sleep_src prss_sleep_src_i (.clk_sys(clk_sys), .cfg_done(cfg), .want(want),
    .sleep_req(sreq));
  // ****
  // helpers
  // ****
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // pready is tied high, so this wait ends after one edge
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // ****
  // scenarios
  // ****
  task t_regs;
    apb(1'b0, 12'h008, 32'h0);
    chk("obuf", 32'hffff, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("ibuf", 32'hff, rd);
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h8, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    $display("t_regs done");
  endtask
  task t_por;
    int k;
    chk("obe_rst", 0, obe);
    chk("ibn_rst", 32'hff, ibn);
    rail <= 1'b1;
    ana <= 1'b1;
    wt(40);
    chk("por_one_rail_low", 0, porb);
    io8 <= 1'b1;
    k = 0;
    while (porb !== 1'b1 && k < 500) begin
      @(posedge clk_sys);
      k++;
    end
    chk("por_delay", 1, k >= 20 && k <= 26);
    chk("cfg_start", 1, cst);
    chk("obe_cfg", 0, obe);
    $display("t_por done");
  endtask
  task t_sleep;
    int k;
    cfg <= 1'b1;
    wt(3);
    chk("obe_user", 32'hffff, obe);
    chk("ibn_user", 32'hff, ibn);
    chk("osc_en", 1, osc);
    want <= 1'b1;
    k = 0;
    while (sst !== 1'b1 && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    wt(10);
    chk("obe_sleep", 0, obe);
    chk("ibn_sleep", 0, ibn);
    chk("cne_sleep", 0, cne);
    gup <= 4'h2;
    wt(2);
    chk("cne_async", 2, cne & 4'h2);
    gup <= 4'h0;
    want <= 1'b0;
    k = 0;
    while (sst !== 1'b0 && k < 10000) begin
      @(posedge clk_sys);
      k++;
    end
    chk("wake_time", 1, k < 10000);
    chk("obe_wake", 32'hffff, obe);
    chk("cne_wake", 32'hf, cne);
    apb(1'b1, 12'h000, 32'hb);
    wt(10);
    chk("sst_sw", 1, sst);
    chk("cne_sw", 0, cne);
    chk("obe_sw", 0, obe);
    apb(1'b1, 12'h000, 32'h8);
    k = 0;
    while (sst !== 1'b0 && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    chk("wake_sw", 1, k < 50);
    apb(1'b0, 12'h010, 32'h0);
    chk("sleep_count", 2, rd);
    $display("t_sleep done");
  endtask
  task t_rails;
    int k;
    io8 <= 1'b0;
    wt(8);
    chk("por_io_drop", 1, porb);
    chk("iod_late", 0, iod);
    io8 <= 1'b1;
    ana <= 1'b0;
    k = 0;
    while (porb !== 1'b0 && k < 10) begin
      @(posedge clk_sys);
      k++;
    end
    chk("por_brownout", 0, porb);
    chk("obe_brownout", 0, obe);
    apb(1'b1, 12'h000, 32'hc);
    ana <= 1'b1;
    k = 0;
    while (porb !== 1'b1 && k < 500) begin
      @(posedge clk_sys);
      k++;
    end
    chk("por_instant", 1, k >= `PRSS_INSTANT_CYC && k <= `PRSS_INSTANT_CYC + 6);
    $display("t_rails done");
  endtask
  initial begin
    wt(16);
    rst_b <= 1'b1;
    t_regs;
    t_por;
    t_sleep;
    t_rails;
    stop_test;
  end
  initial begin
    wt(20000);
    fails++;
    stop_test;
  end
endmodule // testbench
`default_nettype wire
